// [digest_combine_pkg.sv]
// Constants and types of the digest-combine builder.
package digest_combine_pkg;
   localparam logic [7:0] OP_COMBINE   = 8'h15;
   localparam logic [7:0] MODE_OTP     = 8'h01;
   localparam logic [7:0] MODE_SLOT    = 8'h02;
   localparam logic [7:0] MODE_SHARED  = 8'h03;
   localparam logic [7:0] MODE_COUNTER = 8'h04;
   localparam logic [7:0] MODE_KEYCFG  = 8'h05;
   localparam logic [7:0] OTP_MSG_MODE = 8'h00;
   localparam logic [7:0] SEL_HI_PLAIN = 8'h00;
   localparam logic [7:0] SEL_HI_SWAP  = 8'h80;
   localparam logic [7:0] PAIR_MAX_IDX = 8'h01;
   localparam logic [7:0] PAD_BYTE     = 8'h00;
   localparam logic [7:0] RESP_OK      = 8'h00;
   localparam logic [7:0] ERR_PARSE    = 8'h03;
   localparam logic [7:0] ERR_EXEC     = 8'h0F;
   localparam int BLOCK_BITS     = 256;
   localparam int MSG_BYTES      = 96;
   localparam int MSG_BITS       = MSG_BYTES * 8;
   localparam int IDX_W          = 7;
   localparam int LEN_W          = 6;
   localparam int SLOT_W         = 4;
   localparam int SEL_W          = 16;
   localparam int EXTRA_BITS     = 32;
   localparam int CNT_BITS       = 32;
   localparam int ZERO_RUN_BITS  = 200;
   localparam int CNT_TAIL_BITS  = 160;
   localparam int KEYCFG_F_BITS  = 40;
   localparam int KEYCFG_PAD     = 248;
   localparam logic [LEN_W-1:0] LEN_NONE   = 6'h00;
   localparam logic [LEN_W-1:0] LEN_EXTRA  = 6'h04;
   localparam logic [LEN_W-1:0] LEN_SHARED = 6'h20;
   localparam logic [IDX_W-1:0] MSG_LEN_FULL   = 7'h60;
   localparam logic [IDX_W-1:0] MSG_LEN_KEYCFG = 7'h41;
   localparam logic [IDX_W-1:0] IDX_ONE        = 7'h01;
   localparam logic [IDX_W-1:0] IDX_ZERO       = 7'h00;

   typedef enum logic [1:0] {
      KIND_OTP     = 2'h0,
      KIND_SLOT    = 2'h1,
      KIND_COUNTER = 2'h2,
      KIND_KEYCFG  = 2'h3
   } store_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_FETCH = 3'h1,
      ST_PREP  = 3'h3,
      ST_SEND  = 3'h2,
      ST_HASH  = 3'h6,
      ST_RESP  = 3'h7
   } state_t;
endpackage : digest_combine_pkg

// [msg_pick_if.sv]
// Builder to byte picker carrier.
`timescale 1ns/1ns
interface msg_pick_if;
   import digest_combine_pkg::*;
   logic [MSG_BITS-1:0] msg;
   logic [IDX_W-1:0]    len;
   logic [IDX_W-1:0]    idx;
   logic [7:0]          byte_val;
   logic                last;
   modport builder (output msg, output len, output idx, input byte_val, input last);
   modport picker  (input msg, input len, input idx, output byte_val, output last);
endinterface : msg_pick_if

// [msg_byte_pick.sv]
// Picks one message byte, first byte at the top.
`timescale 1ns/1ns
module msg_byte_pick (
   // Message and index
   msg_pick_if.picker pk
);
   import digest_combine_pkg::*;

   logic [MSG_BITS-1:0] shifted;

   if (MSG_BYTES >= (1 << IDX_W)) begin : g_chk
      $error("Index too narrow.");
   end

   always_comb begin
      shifted     = pk.msg << {pk.idx, 3'h0};
      pk.byte_val = shifted[MSG_BITS-1 -: 8];
      pk.last     = (pk.idx == (pk.len - IDX_ONE));
   end
endmodule : msg_byte_pick

// [digest_combine_message_builder.sv]
// Digest-combine message assembly, hash streaming and scratch digest state.
//
// Summary of operation
// - Mode 0x01 fetches the selected OTP block.
// - OTP message: block, opcode, 0x00, selector bytes, serial, 25 zeros, old digest.
// - One response byte: 0x00 on success, else an error code.
// - Valid flag is set on success and cleared on any failure.
// - OTP and counter modes clear the digest-from-slot flag.
// - Slot and shared modes set the digest-from-slot flag.
// - Slot and shared modes store the slot number as digest index.
// - Data-slot mode copies the slot MAC-forbidden attribute into its flag.
// - Mode 0x02 fetches only the lowest 32-byte block of the chosen slot.
// - Slot message: slot, header or extra bytes, serial, 25 zeros, old digest.
// - A MAC-forbidden slot read by mode 0x02 anywhere in a chain blocks MAC use.
// - Random-nonce slots need an internally generated digest in modes 0x02 and 0x03.
// - Mode 0x03 takes 32 input bytes; selector high byte is 0x00 or 0x80.
// - Shared-nonce message puts input or old digest first, the other last.
// - Mode 0x04 includes the selected monotonic counter.
// - Counter message: lead block, header, serial, zero, counter, 20 zeros, old digest.
// - Key-config mode includes the selected slot's configuration.
// - The message is hashed; the digest becomes the scratch digest.
// - Mode 0x05 selects key-config mode with the slot in the selector.
`timescale 1ns/1ns
module digest_combine_message_builder #(
   parameter int                     SLOTS        = 16,
   // Serial bytes: values are arbitrary.
   parameter logic [7:0]             SERIAL_B8    = 8'hA5,
   parameter logic [15:0]            SERIAL_B01   = 16'h3C5A,
   parameter logic [255:0]           COUNTER_LEAD = 256'h0
) (
   // Clock and reset
   input  wire logic                                         sys_clk_i,
   input  wire logic                                         resetn_i,
   // Command from host
   input  wire logic                                         cmd_valid_i,
   input  wire logic [7:0]                                   cmd_opcode_i,
   input  wire logic [7:0]                                   cmd_mode_i,
   input  wire logic [digest_combine_pkg::SEL_W-1:0]         cmd_selector_i,
   input  wire logic [digest_combine_pkg::BLOCK_BITS-1:0]    cmd_data_i,
   input  wire logic [digest_combine_pkg::LEN_W-1:0]         cmd_data_len_i,
   output logic                                              cmd_ready_o,
   // Response byte
   output logic                                              resp_valid_o,
   output logic [7:0]                                        resp_byte_o,
   // Nonce seeding
   input  wire logic                                         nonce_load_i,
   input  wire logic [digest_combine_pkg::BLOCK_BITS-1:0]    nonce_value_i,
   input  wire logic                                         nonce_random_i,
   // Slot policy
   input  wire logic [SLOTS-1:0]                             slot_mac_forbidden_i,
   input  wire logic [SLOTS-1:0]                             slot_needs_random_i,
   // Stored value read port
   output logic                                              mem_rd_req_o,
   output digest_combine_pkg::store_kind_t                   mem_rd_kind_o,
   output logic [digest_combine_pkg::SLOT_W-1:0]             mem_rd_index_o,
   input  wire logic                                         mem_rd_ack_i,
   input  wire logic [digest_combine_pkg::BLOCK_BITS-1:0]    mem_rd_data_i,
   // Hash core
   output logic                                              sha_valid_o,
   output logic [7:0]                                        sha_byte_o,
   output logic                                              sha_last_o,
   input  wire logic                                         sha_ready_i,
   input  wire logic                                         sha_done_i,
   input  wire logic [digest_combine_pkg::BLOCK_BITS-1:0]    sha_digest_i,
   // Scratch digest state
   output logic [digest_combine_pkg::BLOCK_BITS-1:0]         scratch_digest_o,
   output logic                                              digest_valid_flag_o,
   output logic                                              digest_from_slot_flag_o,
   output logic [digest_combine_pkg::SLOT_W-1:0]             digest_slot_index_o,
   output logic                                              mac_forbidden_flag_o,
   output logic                                              digest_random_src_o,
   output logic                                              mac_refuse_o
);
   import digest_combine_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam logic [7:0] SLOT_LIMIT = 8'(SLOTS);

   if (SLOTS < 1 || SLOTS > (1 << SLOT_W)) begin : g_chk
      $error("Bad SLOTS.");
   end

   state_t                state_r;
   state_t                state_nxt;
   logic                  cmd_ready_r;
   logic                  cmd_take;
   logic [7:0]            chk_err;
   logic [SLOT_W-1:0]     sel_slot;
   logic                  slot_ok;
   logic                  forb_in;
   logic                  rand_in;
   logic [7:0]            mode_r;
   logic [7:0]            sel_lo_r;
   logic [7:0]            sel_hi_r;
   logic                  forb_r;
   logic [BLOCK_BITS-1:0] data_r;
   logic [BLOCK_BITS-1:0] stored_r;
   logic                  mem_req_r;
   store_kind_t           mem_kind_r;
   logic [SLOT_W-1:0]     mem_index_r;
   logic                  sha_valid_r;
   logic [7:0]            sha_byte_r;
   logic                  sha_last_r;
   logic [IDX_W-1:0]      idx_r;
   logic [BLOCK_BITS-1:0] digest_r;
   logic                  valid_r;
   logic                  from_slot_r;
   logic [SLOT_W-1:0]     slot_idx_r;
   logic                  mac_forb_r;
   logic                  random_src_r;
   logic                  chain_forb_r;
   logic                  resp_valid_r;
   logic [7:0]            resp_byte_r;
   logic [CNT_BITS-1:0]   cnt_le;

   msg_pick_if pick ();

   msg_byte_pick u_pick (
      .pk (pick.picker)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command checks

   assign sel_slot = cmd_selector_i[SLOT_W-1:0];
   assign slot_ok  = (cmd_selector_i[7:0] < SLOT_LIMIT);
   assign forb_in  = slot_ok && slot_mac_forbidden_i[sel_slot];
   assign rand_in  = slot_ok && slot_needs_random_i[sel_slot];
   assign cmd_take = cmd_valid_i && cmd_ready_r && !nonce_load_i && (state_r == ST_IDLE);

   always_comb begin
      chk_err = RESP_OK;
      if (cmd_opcode_i != OP_COMBINE) begin
         chk_err = ERR_PARSE;
      end else if (!valid_r) begin
         chk_err = ERR_EXEC;
      end else begin
         case (cmd_mode_i)
            MODE_OTP, MODE_COUNTER: begin
               if (cmd_selector_i[15:8] != SEL_HI_PLAIN ||
                   cmd_selector_i[7:0] > PAIR_MAX_IDX ||
                   cmd_data_len_i != LEN_NONE) begin
                  chk_err = ERR_PARSE;
               end
            end
            MODE_SLOT: begin
               if (cmd_selector_i[15:8] != SEL_HI_PLAIN || !slot_ok) begin
                  chk_err = ERR_PARSE;
               end else if (cmd_data_len_i != (forb_in ? LEN_EXTRA : LEN_NONE)) begin
                  chk_err = ERR_PARSE;
               end else if (rand_in && !random_src_r) begin
                  chk_err = ERR_EXEC;
               end
            end
            MODE_SHARED: begin
               if ((cmd_selector_i[15:8] != SEL_HI_PLAIN &&
                    cmd_selector_i[15:8] != SEL_HI_SWAP) || !slot_ok ||
                   cmd_data_len_i != LEN_SHARED) begin
                  chk_err = ERR_PARSE;
               end else if (rand_in && !random_src_r) begin
                  chk_err = ERR_EXEC;
               end
            end
            MODE_KEYCFG: begin
               if (cmd_selector_i[15:8] != SEL_HI_PLAIN || !slot_ok ||
                   cmd_data_len_i != LEN_NONE) begin
                  chk_err = ERR_PARSE;
               end
            end
            default: begin
               chk_err = ERR_PARSE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (cmd_take) begin
               if (chk_err != RESP_OK) begin
                  state_nxt = ST_RESP;
               end else if (cmd_mode_i == MODE_SHARED) begin
                  state_nxt = ST_PREP;
               end else begin
                  state_nxt = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            if (mem_rd_ack_i) begin
               state_nxt = ST_PREP;
            end
         end
         ST_PREP: begin
            state_nxt = ST_SEND;
         end
         ST_SEND: begin
            if (sha_ready_i && sha_last_r) begin
               state_nxt = ST_HASH;
            end
         end
         ST_HASH: begin
            if (sha_done_i) begin
               state_nxt = ST_RESP;
            end
         end
         ST_RESP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r     <= ST_IDLE;
         cmd_ready_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cmd_ready_r <= (state_nxt == ST_IDLE);
      end
   end

   // Command fields hold for the whole pass.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_r   <= 8'h00;
         sel_lo_r <= 8'h00;
         sel_hi_r <= 8'h00;
         forb_r   <= 1'b0;
         data_r   <= '0;
      end else if (cmd_take) begin
         mode_r   <= cmd_mode_i;
         sel_lo_r <= cmd_selector_i[7:0];
         sel_hi_r <= cmd_selector_i[15:8];
         forb_r   <= forb_in;
         data_r   <= cmd_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stored value fetch

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mem_req_r   <= 1'b0;
         mem_kind_r  <= KIND_OTP;
         mem_index_r <= '0;
         stored_r    <= '0;
      end else begin
         if (cmd_take && chk_err == RESP_OK && cmd_mode_i != MODE_SHARED) begin
            mem_req_r   <= 1'b1;
            mem_index_r <= sel_slot;
            case (cmd_mode_i)
               MODE_OTP:     mem_kind_r <= KIND_OTP;
               MODE_SLOT:    mem_kind_r <= KIND_SLOT;
               MODE_COUNTER: mem_kind_r <= KIND_COUNTER;
               default:      mem_kind_r <= KIND_KEYCFG;
            endcase
         end else if (mem_req_r && mem_rd_ack_i) begin
            mem_req_r <= 1'b0;
            stored_r  <= mem_rd_data_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Message assembly

   assign cnt_le = {stored_r[7:0], stored_r[15:8], stored_r[23:16], stored_r[31:24]};

   always_comb begin
      pick.len = MSG_LEN_FULL;
      pick.idx = (state_r == ST_SEND) ? (idx_r + IDX_ONE) : IDX_ZERO;
      case (mode_r)
         MODE_OTP: begin
            pick.msg = {stored_r, OP_COMBINE, OTP_MSG_MODE, sel_lo_r, sel_hi_r,
                        SERIAL_B8, SERIAL_B01, {ZERO_RUN_BITS{1'b0}}, digest_r};
         end
         MODE_SLOT: begin
            pick.msg = {stored_r,
                        forb_r ? data_r[BLOCK_BITS-1 -: EXTRA_BITS]
                               : {OP_COMBINE, MODE_SLOT, sel_lo_r, PAD_BYTE},
                        SERIAL_B8, SERIAL_B01, {ZERO_RUN_BITS{1'b0}}, digest_r};
         end
         MODE_SHARED: begin
            pick.msg = {(sel_hi_r == SEL_HI_SWAP) ? digest_r : data_r,
                        OP_COMBINE, MODE_SHARED, sel_lo_r, PAD_BYTE,
                        SERIAL_B8, SERIAL_B01, {ZERO_RUN_BITS{1'b0}},
                        (sel_hi_r == SEL_HI_SWAP) ? data_r : digest_r};
         end
         MODE_COUNTER: begin
            pick.msg = {COUNTER_LEAD,
                        OP_COMBINE, MODE_COUNTER, sel_lo_r, sel_hi_r,
                        SERIAL_B8, SERIAL_B01, PAD_BYTE, cnt_le,
                        {CNT_TAIL_BITS{1'b0}}, digest_r};
         end
         default: begin
            pick.len = MSG_LEN_KEYCFG;
            pick.msg = {digest_r, OP_COMBINE, MODE_KEYCFG, sel_lo_r, sel_hi_r,
                        SERIAL_B8, SERIAL_B01, PAD_BYTE,
                        stored_r[KEYCFG_F_BITS-1:0], {CNT_TAIL_BITS{1'b0}},
                        {KEYCFG_PAD{1'b0}}};
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hash byte stream

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sha_valid_r <= 1'b0;
         sha_byte_r  <= 8'h00;
         sha_last_r  <= 1'b0;
         idx_r       <= '0;
      end else if (state_r == ST_PREP) begin
         sha_valid_r <= 1'b1;
         sha_byte_r  <= pick.byte_val;
         sha_last_r  <= pick.last;
         idx_r       <= IDX_ZERO;
      end else if (state_r == ST_SEND && sha_ready_i) begin
         if (sha_last_r) begin
            sha_valid_r <= 1'b0;
            sha_last_r  <= 1'b0;
         end else begin
            idx_r      <= idx_r + IDX_ONE;
            sha_byte_r <= pick.byte_val;
            sha_last_r <= pick.last;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scratch digest and flags

   // Nonce loads are taken only while idle, never beside a result.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         digest_r     <= '0;
         valid_r      <= 1'b0;
         from_slot_r  <= 1'b0;
         slot_idx_r   <= '0;
         mac_forb_r   <= 1'b0;
         random_src_r <= 1'b0;
         chain_forb_r <= 1'b0;
      end else if (nonce_load_i && state_r == ST_IDLE) begin
         digest_r     <= nonce_value_i;
         valid_r      <= 1'b1;
         from_slot_r  <= 1'b0;
         mac_forb_r   <= 1'b0;
         random_src_r <= nonce_random_i;
         chain_forb_r <= 1'b0;
      end else if (cmd_take && chk_err != RESP_OK) begin
         valid_r <= 1'b0;
      end else if (state_r == ST_HASH && sha_done_i) begin
         digest_r <= sha_digest_i;
         valid_r  <= 1'b1;
         case (mode_r)
            MODE_SLOT: begin
               from_slot_r  <= 1'b1;
               slot_idx_r   <= sel_lo_r[SLOT_W-1:0];
               mac_forb_r   <= forb_r;
               chain_forb_r <= chain_forb_r | forb_r;
            end
            MODE_SHARED: begin
               from_slot_r <= 1'b1;
               slot_idx_r  <= sel_lo_r[SLOT_W-1:0];
            end
            default: begin
               from_slot_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         resp_valid_r <= 1'b0;
         resp_byte_r  <= RESP_OK;
      end else begin
         resp_valid_r <= (state_nxt == ST_RESP);
         if (cmd_take) begin
            resp_byte_r <= chk_err;
         end else if (state_r == ST_HASH && sha_done_i) begin
            resp_byte_r <= RESP_OK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign cmd_ready_o             = cmd_ready_r;
   assign resp_valid_o            = resp_valid_r;
   assign resp_byte_o             = resp_byte_r;
   assign mem_rd_req_o            = mem_req_r;
   assign mem_rd_kind_o           = mem_kind_r;
   assign mem_rd_index_o          = mem_index_r;
   assign sha_valid_o             = sha_valid_r;
   assign sha_byte_o              = sha_byte_r;
   assign sha_last_o              = sha_last_r;
   assign scratch_digest_o        = digest_r;
   assign digest_valid_flag_o     = valid_r;
   assign digest_from_slot_flag_o = from_slot_r;
   assign digest_slot_index_o     = slot_idx_r;
   assign mac_forbidden_flag_o    = mac_forb_r;
   assign digest_random_src_o     = random_src_r;
   assign mac_refuse_o            = chain_forb_r;
endmodule : digest_combine_message_builder

// [digest_combine_asserts.sv]
// Port checker for the message builder.
`timescale 1ns/1ns
module digest_combine_asserts (
   input wire logic       sys_clk_i, resetn_i, cmd_valid_i, cmd_ready_o, resp_valid_o,
   input wire logic       nonce_load_i, digest_valid_flag_o, mac_refuse_o, mac_forbidden_flag_o,
   input wire logic       sha_valid_o, sha_ready_i, sha_last_o,
   input wire logic [7:0] resp_byte_o, sha_byte_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence take_s; cmd_valid_i && cmd_ready_o && !nonce_load_i; endsequence
   resp_pulse_a: assert property (resp_valid_o |=> !resp_valid_o)
      else $error("long response");
   resp_bound_a: assert property (take_s |=> !cmd_ready_o ##[0:999] resp_valid_o)
      else $error("no response");
   ok_valid_a: assert property (resp_valid_o && resp_byte_o == 8'h00 |-> digest_valid_flag_o)
      else $error("ok but not valid");
   err_clear_a: assert property (resp_valid_o && resp_byte_o != 8'h00 |-> !digest_valid_flag_o)
      else $error("error but valid");
   seed_state_a: assert property (nonce_load_i && cmd_ready_o |=> digest_valid_flag_o && !mac_refuse_o)
      else $error("bad seed");
   sha_hold_a: assert property (sha_valid_o && !sha_ready_i |=> sha_valid_o && $stable(sha_byte_o) && $stable(sha_last_o))
      else $error("stall moved byte");
   chain_keep_a: assert property (mac_refuse_o && !nonce_load_i |=> mac_refuse_o)
      else $error("refusal lost");
   forb_chain_a: assert property (mac_forbidden_flag_o |-> mac_refuse_o)
      else $error("refusal missing");
endmodule : digest_combine_asserts
bind digest_combine_message_builder digest_combine_asserts i_chk (.*);

// [digest_far_model.sv]
// Stored-value memory and hash core, able to stall.
`timescale 1ns/1ns
module digest_far_model (
   input wire logic sys_clk_i, resetn_i, slow, mem_rd_req_o, sha_valid_o, sha_last_o,
   input wire digest_combine_pkg::store_kind_t mem_rd_kind_o,
   input wire logic [3:0] mem_rd_index_o,
   input wire logic [7:0] sha_byte_o,
   output logic mem_rd_ack_i, sha_ready_i, sha_done_i,
   output logic [255:0] mem_rd_data_i, sha_digest_i
);
   logic [7:0] msg [0:95];
   logic [7:0] hn_r, fill;
   logic [6:0] n_r, len_r;
   logic [1:0] wait_r;
   logic tgl_r;
   // A stored block repeats one byte; off acknowledge the bus is inverted.
   assign fill = 8'h40 | {2'h0, mem_rd_kind_o, mem_rd_index_o};
   assign mem_rd_data_i = mem_rd_ack_i ? {32{fill}} : ~{32{fill}};
   assign sha_digest_i = sha_done_i ? {32{hn_r}} : ~{32{hn_r}};
   assign sha_ready_i = !slow || tgl_r;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {mem_rd_ack_i, sha_done_i, tgl_r, wait_r, n_r, len_r} <= '0;
         hn_r <= 8'h01;
      end else begin
         tgl_r <= !tgl_r;
         mem_rd_ack_i <= mem_rd_req_o && !mem_rd_ack_i && sha_ready_i;
         sha_done_i <= wait_r == 2'h1;
         hn_r <= hn_r + {7'h0, sha_done_i};
         if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
         if (sha_valid_o && sha_ready_i) begin
            msg[n_r] <= sha_byte_o;
            n_r <= sha_last_o ? 7'h0 : n_r + 7'h1;
            len_r <= n_r + 7'h1;
            if (sha_last_o) wait_r <= 2'h3;
         end
      end
   end
endmodule : digest_far_model

// [digest_combine_message_builder_tb.sv]
// Bench for the digest-combine message builder.
`timescale 1ns/1ns
module digest_combine_message_builder_tb;
   import digest_combine_pkg::*;
   // Arbitrary serial bytes.
   localparam logic [7:0] SB8 = 8'h96;
   localparam logic [15:0] SB01 = 16'h7E21;
   localparam logic [255:0] V1 = {8{32'h13579BDF}}, V2 = {8{32'h2468ACE0}};
   logic sys_clk_i = '0, resetn_i = '0, cmd_valid_i = '0, nonce_load_i = '0, nonce_random_i = '0;
   logic slow = '0, cmd_ready_o, resp_valid_o, mem_rd_req_o, mem_rd_ack_i, sha_valid_o;
   logic sha_last_o, sha_ready_i, sha_done_i, digest_valid_flag_o, digest_from_slot_flag_o;
   logic mac_forbidden_flag_o, digest_random_src_o, mac_refuse_o;
   logic [7:0] cmd_opcode_i = '0, cmd_mode_i = '0, hn = 8'h01, resp_byte_o, sha_byte_o;
   logic [15:0] cmd_selector_i = '0, slot_mac_forbidden_i = 16'h0020;
   logic [15:0] slot_needs_random_i = 16'h0040;
   logic [5:0] cmd_data_len_i = '0;
   logic [3:0] mem_rd_index_o, digest_slot_index_o;
   logic [255:0] cmd_data_i = '0, nonce_value_i = '0, dg;
   logic [255:0] mem_rd_data_i, sha_digest_i, scratch_digest_o;
   store_kind_t mem_rd_kind_o;
   int bad_count = 0, tests_run = 0, cyc = 0;
   logic [45:0] bad [7] = '{{8'h15, 8'h01, 16'h0002, 6'h00, 8'h03},
      {8'h15, 8'h04, 16'h0002, 6'h00, 8'h03}, {8'h15, 8'h02, 16'h0010, 6'h00, 8'h03},
      {8'h15, 8'h03, 16'h4007, 6'h20, 8'h03}, {8'h16, 8'h01, 16'h0000, 6'h00, 8'h03},
      {8'h15, 8'h00, 16'h0000, 6'h00, 8'h03}, {8'h15, 8'h02, 16'h0005, 6'h00, 8'h03}};
   digest_combine_message_builder #(.SERIAL_B8(SB8), .SERIAL_B01(SB01),
      .COUNTER_LEAD({32{8'h3C}})) i_dut (.*);
   digest_far_model u_far (.*);
   always #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(string nm, logic [255:0] got, logic [255:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic tail(int at, logic [255:0] v);
      for (int i = 0; i < 32; i++) chk("msg byte", u_far.msg[at+i], v[255-8*i -: 8]);
   endtask : tail
   task automatic run(logic [45:0] c, logic [255:0] d);
      do @(negedge sys_clk_i); while (cmd_ready_o !== 1'b1);
      {cmd_opcode_i, cmd_mode_i, cmd_selector_i, cmd_data_len_i} = c[45:8];
      cmd_data_i = d;
      cmd_valid_i = 1'b1;
      @(negedge sys_clk_i);
      cmd_valid_i = 1'b0;
      for (int k = 0; k < 2000 && resp_valid_o !== 1'b1; k++) @(negedge sys_clk_i);
      chk("resp valid", resp_valid_o, 1'b1);
      chk("response", resp_byte_o, c[7:0]);
   endtask : run
   task automatic seed(logic r);
      do @(negedge sys_clk_i); while (cmd_ready_o !== 1'b1);
      {nonce_value_i, nonce_random_i, nonce_load_i} = {V1, r, 1'b1};
      @(negedge sys_clk_i);
      nonce_load_i = 1'b0;
      dg = V1;
      chk("seed", scratch_digest_o, V1);
      chk("random", digest_random_src_o, r);
   endtask : seed
   task automatic ok(logic fs);
      chk("digest", scratch_digest_o, {32{hn}});
      chk("valid", digest_valid_flag_o, 1'b1);
      chk("slot", digest_from_slot_flag_o, fs);
      dg = {32{hn}};
      hn++;
   endtask : ok
   task automatic s_errors;
      run({8'h15, 8'h01, 16'h0000, 6'h00, 8'h0F}, '0);
      foreach (bad[i]) begin
         seed(1'b1);
         run(bad[i], '0);
         chk("valid", digest_valid_flag_o, 1'b0);
      end
      seed(1'b0);
      run({8'h15, 8'h02, 16'h0006, 6'h00, 8'h0F}, '0);
   endtask : s_errors
   task automatic s_otp;
      seed(1'b1);
      run({8'h15, 8'h01, 16'h0001, 6'h00, 8'h00}, '0);
      tail(0, {32{8'h41}});
      tail(32, {32'h15000100, SB8, SB01, 200'h0});
      tail(64, dg);
      ok(1'b0);
   endtask : s_otp
   task automatic s_slot;
      slow = 1'b1;
      run({8'h15, 8'h02, 16'h0003, 6'h00, 8'h00}, '0);
      tail(0, {32{8'h53}});
      tail(32, {32'h15020300, SB8, SB01, 200'h0});
      tail(64, dg);
      ok(1'b1);
      chk("index", digest_slot_index_o, 4'h3);
      chk("no mac", mac_forbidden_flag_o, 1'b0);
      run({8'h15, 8'h02, 16'h0005, 6'h04, 8'h00}, {32'hCAFEF00D, 224'h0});
      tail(32, {32'hCAFEF00D, SB8, SB01, 200'h0});
      ok(1'b1);
      chk("no mac", mac_forbidden_flag_o, 1'b1);
      run({8'h15, 8'h02, 16'h0003, 6'h00, 8'h00}, '0);
      ok(1'b1);
      chk("no mac", mac_forbidden_flag_o, 1'b0);
      chk("chain", mac_refuse_o, 1'b1);
      slow = 1'b0;
   endtask : s_slot
   task automatic s_shared;
      for (int h = 0; h < 2; h++) begin
         run({8'h15, 8'h03, h ? 8'h80 : 8'h00, 8'h07, 6'h20, 8'h00}, V2);
         tail(0, h ? dg : V2);
         tail(32, {32'h15030700, SB8, SB01, 200'h0});
         tail(64, h ? V2 : dg);
         ok(1'b1);
         chk("index", digest_slot_index_o, 4'h7);
      end
   endtask : s_shared
   task automatic s_counter_keycfg;
      run({8'h15, 8'h04, 16'h0001, 6'h00, 8'h00}, '0);
      tail(0, {32{8'h3C}});
      tail(32, {32'h15040100, SB8, SB01, 8'h00, {4{8'h61}}, 160'h0});
      tail(64, dg);
      ok(1'b0);
      run({8'h15, 8'h05, 16'h0002, 6'h00, 8'h00}, '0);
      tail(0, dg);
      tail(32, {32'h15050200, SB8, SB01, 8'h00, {5{8'h72}}, 152'h0});
      chk("length", u_far.len_r, 7'h41);
      ok(1'b0);
   endtask : s_counter_keycfg
   initial begin
      repeat (5) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      s_errors();
      s_otp();
      s_slot();
      s_shared();
      s_counter_keycfg();
      close_out();
   end
endmodule : digest_combine_message_builder_tb
